// >>> shared/fsp_pkg.sv
// shared constants and types for the flash sector request sequencer
package fsp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // flash geometry and request limits
  localparam logic [7:0] SECTOR_COUNT = 8'h08;
  localparam int SECTOR_SHIFT = 15;
  localparam logic [15:0] SECTOR_BYTES = 16'h8000;
  localparam logic [31:0] FLASH_BYTES = 32'h0004_0000;
  localparam logic [15:0] MAX_LEN = 16'h8000;
  localparam logic [15:0] PAGEWORD_BYTES = 16'h0010;
  localparam logic [7:0] FIRST_DATA_SECTOR = 8'h01;
  localparam logic [7:0] OVERLAY_BLOCKS = 8'h04;
  localparam logic [15:0] FILL_RESET = 16'h8000;

  ////////////////////////////////////////////////////////////////////////////
  // device type selection codes
  localparam logic [3:0] DT_PART_SMALL = 4'h0;
  localparam logic [3:0] DT_PART_PWR_FIRST = 4'h1;
  localparam logic [3:0] DT_PART_PWR_LAST = 4'h4;
  localparam logic [3:0] DT_OVERLAY_PART = 4'h5;
  localparam logic [3:0] DT_CUSTOM_PART_SELECT = 4'h6;
  localparam logic [3:0] DT_ONCHIP_ARRAY_SELECT = 4'h7;
  localparam logic [3:0] DT_AUTO_DETECT_SELECT = 4'h8;
  localparam logic [3:0] DT_MAX = 4'h8;

  ////////////////////////////////////////////////////////////////////////////
  // operations, states and link payloads
  typedef enum logic [2:0] {
    OP_SELECT = 3'h0,
    OP_ERASE = 3'h1,
    OP_PROGRAM = 3'h2,
    OP_READ = 3'h3,
    OP_PDOWN = 3'h4,
    OP_PUP = 3'h5
  } fsp_op_t;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_PAGE = 4'h2,
    ST_ISSUE = 4'h4,
    ST_WAIT = 4'h8
  } fsp_state_t;

  typedef struct packed {
    fsp_op_t op;
    logic [3:0] dtype;
    logic [2:0] sector;
    logic [31:0] addr;
    logic [7:0] divisor;
    logic [7:0] slave_sel;
    logic err_en;
    logic [127:0] data;
  } fsp_cmd_t;

  typedef struct packed {
    logic ok;
    logic [7:0] rdata;
  } fsp_res_t;

endpackage

// >>> hdl/fsp_xfer.sv
// toggle handshake that carries one word from one clock domain to another
`timescale 1ns/1ps
module fsp_xfer #(
  parameter int W = 8
) (
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic send,
  input wire logic [W-1:0] send_data,
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic got,
  output logic [W-1:0] got_data
);

  logic tgl;
  logic [W-1:0] hold;
  logic meta;
  logic sync;
  logic last;
  wire logic edge_seen = sync ^ last;

  ////////////////////////////////////////////////////////////////////////////
  // source side: hold the word, flip the toggle
  always_ff @(posedge src_clk) begin
    if (!src_rst_n) begin
      tgl <= 1'b0;
      hold <= '0;
    end else if (send) begin
      tgl <= ~tgl;
      hold <= send_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // destination side: two-flop sync, edge gives a pulse and the stable word
  always_ff @(posedge dst_clk) begin
    if (!dst_rst_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
      got <= 1'b0;
      got_data <= '0;
    end else begin
      meta <= tgl;
      sync <= meta;
      last <= sync;
      got <= edge_seen;
      if (edge_seen) begin
        got_data <= hold; // word stood still since the toggle flipped
      end
    end
  end

endmodule

// >>> hdl/fsp_page_mem.sv
// sixteen-byte pageword staging buffer with a registered word read
`timescale 1ns/1ps
module fsp_page_mem (
  input wire logic mclk,
  input wire logic wr_en,
  input wire logic [3:0] wr_idx,
  input wire logic [7:0] wr_data,
  input wire logic rd_en,
  output logic [127:0] rd_word
);

  logic [7:0] mem [16];

  // byte write from the user side
  always_ff @(posedge mclk) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  // whole pageword read, byte 0 in the low lane
  for (genvar i = 0; i < 16; i++) begin : g_lane
    always_ff @(posedge mclk) begin
      if (rd_en) begin
        rd_word[8*i +: 8] <= mem[i];
      end
    end
  end

endmodule

// >>> hdl/fsp_host.sv
// requester that drives a flash sector controller with checked requests
//
// Overview of operation
// - sector number must be zero to seven
// - erase sector before reprogramming any data
// - program whole 16-byte units, aligned start
// - program byte count at most 0x8000
// - never program a non-blank pageword twice
// - addresses are byte offsets into flash
// - read byte count from one to 0x8000
// - power-down before sleep, power-up before access
// - no power-down while on-chip array selected
// - reselect device type before switching memories
// - custom part init carries divisor and select
// - never erase sectors holding application code
`timescale 1ns/1ps
module fsp_host (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic req_valid,
  output logic req_ready,
  input wire fsp_pkg::fsp_op_t req_op,
  input wire logic [3:0] req_dtype,
  input wire logic [7:0] req_sector,
  input wire logic [31:0] req_addr,
  input wire logic [15:0] req_len,
  input wire logic [7:0] req_divisor,
  input wire logic [7:0] req_slave_sel,
  input wire logic req_err_en,
  input wire logic pw_wr_en,
  input wire logic [3:0] pw_wr_idx,
  input wire logic [7:0] pw_wr_data,
  output logic pw_need,
  input wire logic pw_go,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic done,
  output logic done_ok,
  output logic done_reject,
  output logic flash_err,
  output logic lk_req,
  output fsp_pkg::fsp_cmd_t lk_cmd,
  input wire logic lk_done,
  input wire fsp_pkg::fsp_res_t lk_res,
  input wire logic lk_err_irq
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  fsp_pkg::fsp_state_t state;
  fsp_pkg::fsp_state_t next_state;
  fsp_pkg::fsp_op_t op;
  logic [3:0] cmd_dtype;
  logic [3:0] dtype_cur;
  logic sel_valid;
  logic powered_down;
  logic [2:0] sector;
  logic [31:0] addr;
  logic [15:0] remain;
  logic [7:0] divisor;
  logic [7:0] slave_sel;
  logic err_en;
  logic [15:0] fill [8];
  logic [127:0] pw_word;
  logic res_got;
  fsp_pkg::fsp_res_t res_data;
  logic cmd_got;
  fsp_pkg::fsp_cmd_t cmd_data;
  fsp_pkg::fsp_cmd_t cmd_out;
  logic lrst_meta;
  logic lrst_n;
  logic err_meta;

  ////////////////////////////////////////////////////////////////////////////
  // request checks against the current selection and sector fill
  wire logic [2:0] addr_sec = req_addr[17:15];
  wire logic [15:0] fill_sel = fill[addr_sec];
  wire logic [16:0] end_off = {2'b00, req_addr[14:0]} + {1'b0, req_len};
  wire logic in_flash = req_addr < fsp_pkg::FLASH_BYTES;
  wire logic in_sector = end_off <= {1'b0, fsp_pkg::SECTOR_BYTES};
  wire logic len_ok = (|req_len) && (req_len <= fsp_pkg::MAX_LEN);
  wire logic is_onchip = (dtype_cur == fsp_pkg::DT_ONCHIP_ARRAY_SELECT)
                       || (dtype_cur == fsp_pkg::DT_AUTO_DETECT_SELECT);
  wire logic access_ok = sel_valid && !powered_down;
  wire logic unit_ok = (req_addr[3:0] == 4'h0) && (req_len[3:0] == 4'h0);
  wire logic blank_ok = {1'b0, req_addr[14:0]} >= fill_sel;
  wire logic prog_ok = access_ok && in_flash && len_ok && in_sector && unit_ok && blank_ok;
  wire logic read_ok = access_ok && in_flash && len_ok && in_sector;
  wire logic overlay = dtype_cur == fsp_pkg::DT_OVERLAY_PART;
  wire logic [7:0] erase_top = overlay ? fsp_pkg::OVERLAY_BLOCKS : fsp_pkg::SECTOR_COUNT;
  wire logic erase_ok = access_ok && (req_sector < erase_top)
                      && (req_sector >= fsp_pkg::FIRST_DATA_SECTOR);
  wire logic power_ok = sel_valid && !is_onchip;
  wire logic select_ok = req_dtype <= fsp_pkg::DT_MAX;
  wire logic req_ok = (req_op == fsp_pkg::OP_SELECT) ? select_ok :
                      (req_op == fsp_pkg::OP_ERASE) ? erase_ok :
                      (req_op == fsp_pkg::OP_PROGRAM) ? prog_ok :
                      (req_op == fsp_pkg::OP_READ) ? read_ok :
                      (req_op == fsp_pkg::OP_PDOWN) ? power_ok :
                      (req_op == fsp_pkg::OP_PUP) ? power_ok : 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // sequencing terms
  wire logic in_idle = state == fsp_pkg::ST_IDLE;
  wire logic in_page = state == fsp_pkg::ST_PAGE;
  wire logic in_wait = state == fsp_pkg::ST_WAIT;
  wire logic accept = in_idle && req_valid && req_ok;
  wire logic reject = in_idle && req_valid && !req_ok;
  wire logic is_prog = op == fsp_pkg::OP_PROGRAM;
  wire logic is_read = op == fsp_pkg::OP_READ;
  wire logic last_unit = is_prog ? (remain == fsp_pkg::PAGEWORD_BYTES) :
                         is_read ? (remain == 16'h0001) : 1'b1;
  wire logic step_ok = in_wait && res_got && res_data.ok;
  wire logic finish = in_wait && res_got && (!res_data.ok || last_unit);
  wire logic cmd_send = state == fsp_pkg::ST_ISSUE;

  assign req_ready = in_idle;
  assign pw_need = in_page;
  // next state
  always_comb begin
    next_state = state;
    case (state)
      fsp_pkg::ST_IDLE: begin
        if (accept) begin
          next_state = (req_op == fsp_pkg::OP_PROGRAM) ? fsp_pkg::ST_PAGE : fsp_pkg::ST_ISSUE;
        end
      end
      fsp_pkg::ST_PAGE: begin
        if (pw_go) begin
          next_state = fsp_pkg::ST_ISSUE;
        end
      end
      fsp_pkg::ST_ISSUE: begin
        next_state = fsp_pkg::ST_WAIT;
      end
      fsp_pkg::ST_WAIT: begin
        if (finish) begin
          next_state = fsp_pkg::ST_IDLE;
        end else if (res_got) begin
          next_state = is_prog ? fsp_pkg::ST_PAGE : fsp_pkg::ST_ISSUE;
        end
      end
      default: begin
        next_state = fsp_pkg::ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= fsp_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // captured request fields
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      op <= fsp_pkg::OP_SELECT;
      cmd_dtype <= 4'h0;
      sector <= 3'h0;
      divisor <= 8'h00;
      slave_sel <= 8'h00;
      err_en <= 1'b0;
    end else if (accept) begin
      op <= req_op;
      cmd_dtype <= req_dtype;
      sector <= req_sector[2:0];
      divisor <= req_divisor;
      slave_sel <= req_slave_sel;
      err_en <= req_err_en;
    end
  end

  // walking offset and bytes left
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      addr <= 32'h0000_0000;
      remain <= 16'h0000;
    end else if (accept) begin
      addr <= req_addr;
      remain <= req_len;
    end else if (step_ok && is_prog) begin
      addr <= addr + {16'h0000, fsp_pkg::PAGEWORD_BYTES};
      remain <= remain - fsp_pkg::PAGEWORD_BYTES;
    end else if (step_ok && is_read) begin
      addr <= addr + 32'h0000_0001;
      remain <= remain - 16'h0001;
    end
  end

  // selection and power tracking
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dtype_cur <= 4'h0;
      sel_valid <= 1'b0;
      powered_down <= 1'b0;
    end else if (step_ok && op == fsp_pkg::OP_SELECT) begin
      dtype_cur <= cmd_dtype;
      sel_valid <= 1'b1;
    end else if (step_ok && op == fsp_pkg::OP_PDOWN) begin
      powered_down <= 1'b1;
    end else if (step_ok && op == fsp_pkg::OP_PUP) begin
      powered_down <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-sector fill mark: pagewords below it may not be blank
  for (genvar i = 0; i < 8; i++) begin : g_fill
    wire logic erase_hit = step_ok && (op == fsp_pkg::OP_ERASE) && (sector == 3'(i));
    wire logic prog_hit = in_wait && res_got && is_prog && (addr[17:15] == 3'(i));
    always_ff @(posedge mclk) begin
      if (!rst_n) begin
        fill[i] <= fsp_pkg::FILL_RESET; // unknown content counts as used
      end else if (erase_hit) begin
        fill[i] <= 16'h0000;
      end else if (prog_hit) begin
        fill[i] <= {1'b0, addr[14:0]} + fsp_pkg::PAGEWORD_BYTES;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pageword staging buffer, read as the user releases it
  fsp_page_mem u_page (
    .mclk(mclk),
    .wr_en(pw_wr_en),
    .wr_idx(pw_wr_idx),
    .wr_data(pw_wr_data),
    .rd_en(in_page && pw_go),
    .rd_word(pw_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // completion and read data toward the user
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      done <= 1'b0;
      done_ok <= 1'b0;
      done_reject <= 1'b0;
    end else begin
      done <= reject || finish;
      if (reject || finish) begin
        done_ok <= finish && res_data.ok;
        done_reject <= reject;
      end
    end
  end
  // one byte per read step
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_valid <= step_ok && is_read;
      if (step_ok && is_read) begin
        rd_data <= res_data.rdata;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command payload and the two crossings
  always_comb begin
    cmd_out.op = op;
    cmd_out.dtype = (op == fsp_pkg::OP_SELECT) ? cmd_dtype : dtype_cur;
    cmd_out.sector = sector;
    cmd_out.addr = addr;
    cmd_out.divisor = divisor;
    cmd_out.slave_sel = slave_sel;
    cmd_out.err_en = err_en;
    cmd_out.data = pw_word;
  end

  fsp_xfer #(.W($bits(fsp_pkg::fsp_cmd_t))) u_cmd_x (
    .src_clk(mclk),
    .src_rst_n(rst_n),
    .send(cmd_send),
    .send_data(cmd_out),
    .dst_clk(link_clk),
    .dst_rst_n(lrst_n),
    .got(cmd_got),
    .got_data(cmd_data)
  );

  fsp_xfer #(.W($bits(fsp_pkg::fsp_res_t))) u_res_x (
    .src_clk(link_clk),
    .src_rst_n(lrst_n),
    .send(lk_req && lk_done),
    .send_data(lk_res),
    .dst_clk(mclk),
    .dst_rst_n(rst_n),
    .got(res_got),
    .got_data(res_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // link side: reset sync and request held until the controller finishes
  always_ff @(posedge link_clk) begin
    lrst_meta <= rst_n;
    lrst_n <= lrst_meta;
  end

  // controller stays busy until done, so one request stands at a time
  always_ff @(posedge link_clk) begin
    if (!lrst_n) begin
      lk_req <= 1'b0;
      lk_cmd <= '0;
    end else if (cmd_got) begin
      lk_req <= 1'b1;
      lk_cmd <= cmd_data;
    end else if (lk_done) begin
      lk_req <= 1'b0;
    end
  end

  // error interrupt level brought into the request domain
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      err_meta <= 1'b0;
      flash_err <= 1'b0;
    end else begin
      err_meta <= lk_err_irq;
      flash_err <= err_meta && err_en;
    end
  end

endmodule

// >>> bench/fsp_host_sva.sv
// concurrent checks on the flash request sequencer ports
`timescale 1ns/1ps
module fsp_host_chk (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic link_clk,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire fsp_pkg::fsp_op_t req_op,
  input wire logic [7:0] req_sector,
  input wire logic [31:0] req_addr,
  input wire logic [15:0] req_len,
  input wire logic rd_valid,
  input wire logic done,
  input wire logic done_ok,
  input wire logic done_reject,
  input wire logic flash_err,
  input wire logic lk_req,
  input wire fsp_pkg::fsp_cmd_t lk_cmd,
  input wire logic lk_done,
  input wire logic lk_err_irq
);
  // request decode
  wire logic take = req_valid && req_ready;
  wire logic t_prog = take && req_op == fsp_pkg::OP_PROGRAM;
  wire logic t_read = take && req_op == fsp_pkg::OP_READ;
  wire logic t_erase = take && req_op == fsp_pkg::OP_ERASE;
  wire logic [16:0] rd_end = {2'b00, req_addr[14:0]} + {1'b0, req_len};
  ////////////////////////////////////////////////////////////////////////////
  a_prog_align: assert property (@(posedge mclk) disable iff (!rst_n)
    t_prog && (req_addr[3:0] != 4'h0 || req_len[3:0] != 4'h0) |=> done && done_reject)
    else $error("unaligned program not refused");
  a_prog_len: assert property (@(posedge mclk) disable iff (!rst_n)
    t_prog && req_len > 16'h8000 |=> done && done_reject) else $error("long program taken");
  a_erase_sector: assert property (@(posedge mclk) disable iff (!rst_n)
    t_erase && (req_sector == 8'h00 || req_sector > 8'h07) |=> done && done_reject)
    else $error("bad erase sector taken");
  a_read_len: assert property (@(posedge mclk) disable iff (!rst_n)
    t_read && req_len == 16'h0000 |=> done && done_reject) else $error("empty read taken");
  a_read_cross: assert property (@(posedge mclk) disable iff (!rst_n)
    t_read && rd_end > 17'h08000 |=> done && done_reject && !rd_valid)
    else $error("sector crossing read gave data");
  a_lk_hold: assert property (@(posedge link_clk) disable iff (!rst_n)
    lk_req && !lk_done |=> lk_req && $stable(lk_cmd)) else $error("link command not held");
  a_lk_drop: assert property (@(posedge link_clk) disable iff (!rst_n)
    lk_req && lk_done |=> !lk_req) else $error("link request not dropped");
  a_irq_follow: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(lk_err_irq) && lk_cmd.err_en |-> ##[1:4] flash_err) else $error("error irq not passed on");
  // main scenarios
  c_done_ok: cover property (@(posedge mclk) done && done_ok);
  c_read: cover property (@(posedge mclk) rd_valid);
  c_irq: cover property (@(posedge mclk) flash_err);
endmodule
bind fsp_host fsp_host_chk chk_i (
  .mclk, .rst_n, .link_clk, .req_valid, .req_ready, .req_op, .req_sector, .req_addr, .req_len,
  .rd_valid, .done, .done_ok, .done_reject, .flash_err, .lk_req, .lk_cmd, .lk_done, .lk_err_irq
);

// >>> bench/fsp_flash_model.sv
// behavioural flash controller answering the sequencer's link commands
`timescale 1ns/1ps
module fsp_flash_model (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic lk_req,
  input wire fsp_pkg::fsp_cmd_t lk_cmd,
  input wire logic slow,
  input wire logic fail,
  input wire logic dbl,
  output logic lk_done,
  output fsp_pkg::fsp_res_t lk_res,
  output logic lk_err_irq
);
  logic [7:0] mem [0:262143];
  logic [7:0] div = 8'h00;
  logic [7:0] ssel = 8'h00;
  int n_pwr = 0;
  int cnt = 0;
  logic seen = 1'b0;
  // power commands only reach the parts that know them
  wire logic pwr_ok = lk_cmd.dtype >= fsp_pkg::DT_PART_PWR_FIRST &&
    lk_cmd.dtype <= fsp_pkg::DT_PART_PWR_LAST;
  ////////////////////////////////////////////////////////////////////////////
  // blank array at start
  initial for (int i = 0; i < 262144; i++) mem[i] = 8'hff;
  // carry out one command and build its result
  task automatic serve();
    fsp_pkg::fsp_res_t r;
    logic [17:0] a;
    r = {!fail, 8'h00};
    a = lk_cmd.addr[17:0];
    if (!lk_cmd.err_en) lk_err_irq <= 1'b0;
    case (lk_cmd.op)
      fsp_pkg::OP_SELECT: if (lk_cmd.dtype == fsp_pkg::DT_CUSTOM_PART_SELECT) begin
        div = lk_cmd.divisor;
        ssel = lk_cmd.slave_sel;
      end
      fsp_pkg::OP_ERASE: for (int i = 0; i < 32768; i++)
          mem[{lk_cmd.sector, i[14:0]}] = 8'hff;
      fsp_pkg::OP_PROGRAM: for (int i = 0; i < 16; i++)
          mem[a + i] = mem[a + i] & lk_cmd.data[8 * i +: 8];
      fsp_pkg::OP_READ: begin
        r = {1'b1, mem[a]};
        if (dbl && lk_cmd.err_en) lk_err_irq <= 1'b1;
      end
      default: if (pwr_ok) n_pwr++;
    endcase
    lk_res <= r;
  endtask
  // answer each command once, quickly or after a stall
  always @(posedge link_clk) begin
    lk_done <= 1'b0;
    lk_res <= ~lk_res; // released result lines keep changing
    if (!rst_n) begin
      lk_res <= '0;
      lk_err_irq <= 1'b0;
      seen <= 1'b0;
      cnt <= 0;
    end else if (!lk_req) begin
      seen <= 1'b0;
      cnt <= 0;
    end else if (!seen && cnt < (slow ? 6 : 1)) begin
      cnt <= cnt + 1;
    end else if (!seen) begin
      seen <= 1'b1;
      lk_done <= 1'b1;
      serve();
    end
  end
endmodule

// >>> bench/fsp_host_test.sv
// self-checking bench for the flash request sequencer
`timescale 1ns/1ps
module fsp_host_test;
  logic mclk = 1'b0, link_clk = 1'b0, rst_n = 1'b0, req_valid = 1'b0, req_err_en = 1'b0;
  logic pw_wr_en = 1'b0, pw_go = 1'b0, slow = 1'b0, fail = 1'b0, dbl = 1'b0;
  logic [3:0] req_dtype = 4'h0, pw_wr_idx = 4'h0;
  logic [7:0] req_sector = 8'h00, req_divisor = 8'h00, req_slave_sel = 8'h00, pw_wr_data = 8'h00;
  logic [31:0] req_addr = 32'h0;
  logic [15:0] req_len = 16'h0;
  fsp_pkg::fsp_op_t req_op = fsp_pkg::OP_SELECT;
  logic req_ready, pw_need, rd_valid, done, done_ok, done_reject, flash_err, lk_req, lk_done;
  logic lk_err_irq;
  logic [7:0] rd_data;
  fsp_pkg::fsp_cmd_t lk_cmd;
  fsp_pkg::fsp_res_t lk_res;
  int n_fail = 0, num_checks = 0, cyc = 0;
  logic [7:0] got [$];
  ////////////////////////////////////////////////////////////////////////////
  fsp_host uut (
    .mclk, .rst_n, .link_clk, .req_valid, .req_ready, .req_op, .req_dtype, .req_sector,
    .req_addr, .req_len, .req_divisor, .req_slave_sel, .req_err_en, .pw_wr_en, .pw_wr_idx,
    .pw_wr_data, .pw_need, .pw_go, .rd_valid, .rd_data, .done, .done_ok, .done_reject,
    .flash_err, .lk_req, .lk_cmd, .lk_done, .lk_res, .lk_err_irq
  );
  fsp_flash_model fm (
    .link_clk, .rst_n, .lk_req, .lk_cmd, .slow, .fail, .dbl, .lk_done, .lk_res, .lk_err_irq
  );
  // clocks, read capture and hang guard
  initial forever #10 mclk = ~mclk;
  initial forever #7.5 link_clk = ~link_clk;
  always @(posedge mclk) if (rd_valid === 1'b1) got.push_back(rd_data);
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_of_test();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit c, input string m);
    num_checks++;
    if (!c) begin
      n_fail++;
      $display("BAD %0t %s", $time, m);
    end
  endtask
  // one request; ad also carries sector and device type; pagewords fed on demand
  task automatic req(input fsp_pkg::fsp_op_t op, input logic [31:0] ad, input logic [15:0] ln,
      input logic rej, input logic ok);
    int n;
    int pw;
    n = 0;
    pw = 0;
    req_op = op;
    req_addr = ad;
    req_sector = ad[7:0];
    req_dtype = ad[3:0];
    req_len = ln;
    req_valid = 1'b1;
    while (req_ready !== 1'b1) begin
      @(posedge mclk);
      #1;
    end
    @(posedge mclk);
    #1 req_valid = 1'b0;
    while (done !== 1'b1 && n < 4000) begin
      if (pw_need === 1'b1) begin
        for (int i = 0; i < 16; i++) begin
          pw_wr_en = 1'b1;
          pw_wr_idx = i[3:0];
          pw_wr_data = 8'ha5 ^ {pw[3:0], i[3:0]};
          @(posedge mclk);
          #1;
        end
        pw_wr_en = 1'b0;
        pw_go = 1'b1;
        pw++;
      end
      @(posedge mclk);
      #1 pw_go = 1'b0;
      n++;
    end
    chk(done === 1'b1 && done_reject === rej && (rej || done_ok === ok), "request result");
    // let the last read byte reach the capture queue
    @(posedge mclk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_sel();
    req(fsp_pkg::OP_ERASE, 32'h1, 16'h0, 1'b1, 1'b0);
    req(fsp_pkg::OP_SELECT, 32'h9, 16'h0, 1'b1, 1'b0);
    req_divisor = 8'h2c;
    req_slave_sel = 8'h03;
    req(fsp_pkg::OP_SELECT, 32'h6, 16'h0, 1'b0, 1'b1);
    chk(fm.div === 8'h2c, "custom init divisor");
    chk(fm.ssel === 8'h03, "custom init slave select");
    req(fsp_pkg::OP_SELECT, 32'h7, 16'h0, 1'b0, 1'b1);
  endtask
  task automatic t_erase();
    req(fsp_pkg::OP_SELECT, 32'h5, 16'h0, 1'b0, 1'b1);
    req(fsp_pkg::OP_ERASE, 32'h4, 16'h0, 1'b1, 1'b0);
    req(fsp_pkg::OP_SELECT, 32'h7, 16'h0, 1'b0, 1'b1);
    req(fsp_pkg::OP_ERASE, 32'h0, 16'h0, 1'b1, 1'b0);
    req(fsp_pkg::OP_ERASE, 32'h8, 16'h0, 1'b1, 1'b0);
    fail = 1'b1;
    req(fsp_pkg::OP_ERASE, 32'h1, 16'h0, 1'b0, 1'b0);
    fail = 1'b0;
    req(fsp_pkg::OP_ERASE, 32'h1, 16'h0, 1'b0, 1'b1);
  endtask
  task automatic t_prog();
    int n0;
    req(fsp_pkg::OP_PROGRAM, 32'h8008, 16'h20, 1'b1, 1'b0);
    req(fsp_pkg::OP_PROGRAM, 32'h8000, 16'h8010, 1'b1, 1'b0);
    req(fsp_pkg::OP_PROGRAM, 32'h8000, 16'h20, 1'b0, 1'b1);
    req(fsp_pkg::OP_PROGRAM, 32'h8000, 16'h10, 1'b1, 1'b0);
    n0 = got.size();
    req(fsp_pkg::OP_READ, 32'h8010, 16'h4, 1'b0, 1'b1);
    for (int i = 0; i < 4; i++)
      chk(got[n0 + i] === (8'ha5 ^ {4'h1, i[3:0]}), "read data");
    req(fsp_pkg::OP_READ, 32'h8000, 16'h0, 1'b1, 1'b0);
    req(fsp_pkg::OP_READ, 32'hfffe, 16'h4, 1'b1, 1'b0);
    req(fsp_pkg::OP_ERASE, 32'h1, 16'h0, 1'b0, 1'b1);
    req(fsp_pkg::OP_READ, 32'h8011, 16'h1, 1'b0, 1'b1);
    chk(got.size() == n0 + 5 && got[n0 + 4] === 8'hff, "read count or blank");
  endtask
  task automatic t_power();
    int p;
    p = fm.n_pwr;
    req(fsp_pkg::OP_PDOWN, 32'h7, 16'h0, 1'b1, 1'b0);
    slow = 1'b1;
    req(fsp_pkg::OP_SELECT, 32'h1, 16'h0, 1'b0, 1'b1);
    req(fsp_pkg::OP_PDOWN, 32'h1, 16'h0, 1'b0, 1'b1);
    req(fsp_pkg::OP_ERASE, 32'h1, 16'h0, 1'b1, 1'b0);
    req(fsp_pkg::OP_PUP, 32'h1, 16'h0, 1'b0, 1'b1);
    chk(fm.n_pwr == p + 2, "power commands");
    req(fsp_pkg::OP_SELECT, 32'h0, 16'h0, 1'b0, 1'b1);
    req(fsp_pkg::OP_PDOWN, 32'h0, 16'h0, 1'b0, 1'b1);
    req(fsp_pkg::OP_PUP, 32'h0, 16'h0, 1'b0, 1'b1);
    chk(fm.n_pwr == p + 2, "unsupported part powered");
  endtask
  task automatic t_irq();
    req_err_en = 1'b1;
    req(fsp_pkg::OP_SELECT, 32'h7, 16'h0, 1'b0, 1'b1);
    dbl = 1'b1;
    req(fsp_pkg::OP_READ, 32'h8000, 16'h1, 1'b0, 1'b1);
    repeat (8) @(posedge mclk);
    #1 chk(flash_err === 1'b1, "no error irq");
    req_err_en = 1'b0;
    req(fsp_pkg::OP_READ, 32'h8000, 16'h1, 1'b0, 1'b1);
    repeat (8) @(posedge mclk);
    #1 chk(flash_err === 1'b0, "irq not gated");
  endtask
  task automatic end_of_test();
    if (n_fail == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (5) @(posedge mclk);
    #1 rst_n = 1'b1;
    t_sel();
    t_erase();
    t_prog();
    t_power();
    t_irq();
    end_of_test();
  end
endmodule
